// *** verilog/usr_rx.sv ***
/*
 * receive path of the universal serial unit: async oversampled
 * uart, synchronous receive, spi receive, buffer, error flags.
 * assumes BAUD_TICK pulses once per oversample period, all pins
 * synchronous to CLK, and software reading status before data.
 */
// Notes on behaviour
// - receive path runs only while enabled
// - valid start bit begins frame; bits shifted
// - first stop bit completes frame; second ignored
// - nine-bit chars put ninth bit aside
// - two-entry buffer keeps flags per character
// - complete flag high while buffer holds data
// - interrupt while flag, enable, global enable
// - frame error reflects first stop bit
// - overrun on full buffer; drop until read
// - parity error; reads zero when disabled
// - compare computed and received parity
// - disable is immediate, flushes, frees pin
// - sixteen or eight samples per bit
// - start accepted by majority of centre samples
// - resynchronise on every start bit
// - majority vote per data, parity bit
// - stop valid on two of three high
// - spi mode selects slave select handling
// - spi renames receive and transmit pins
// - spi roles, bit order, buffered receive
// - frame is lsb first, parity before stop
// - even parity is xor; odd inverted
// - polarity picks sampling serial clock edge
`timescale 1ns/1ps
module usr_rx
    import usr_pkg::*;
#(
    parameter int BUF_DEPTH = RX_BUF_DEPTH
) (
    // clock, reset, clock enable
    input  wire logic       CLK,
    input  wire logic       RST_N,
    input  wire logic       CE,
    // configuration
    input  wire logic       RX_ENABLE,
    input  wire logic [1:0] MODE,
    input  wire logic       DOUBLE_SPEED,
    input  wire logic [2:0] CHAR_SIZE,
    input  wire logic       PARITY_EN,
    input  wire logic       PARITY_ODD,
    input  wire logic       CLOCK_POL,
    input  wire logic       MASTER,
    input  wire logic       SS_OUT_EN,
    input  wire logic       LSB_FIRST,
    input  wire logic       RXC_IE,
    input  wire logic       GLOBAL_IE,
    // timing and pins
    input  wire logic       BAUD_TICK,
    input  wire logic       RXD,
    input  wire logic       SCK_IN,
    input  wire logic       SS_IN_N,
    // software read of the data register
    input  wire logic       RD_POP,
    // status and data
    output logic [7:0]      RX_DATA,
    output logic            RX_NINTH,
    output logic            FRAME_ERR,
    output logic            PARITY_ERR,
    output logic            OVERRUN,
    output logic            RX_COMPLETE,
    output logic            RX_IRQ,
    output logic            RX_BUSY,
    output logic            RXD_GPIO_FREE,
    output logic            SS_OUT_N,
    output logic            SS_OE
);
    usr_state_t         state_q;
    logic [4:0]         cnt_q;
    logic [1:0]         ones_q;
    logic [3:0]         idx_q;
    logic [8:0]         shift_q;
    logic               par_q;
    logic               perr_q;
    logic               prev_q;
    logic               overrun_q;
    logic               dor_mark_q;

    logic               async_m;
    logic               spi_m;
    logic [4:0]         os_last;
    logic [4:0]         v_lo;
    logic [4:0]         v_hi;
    logic               samp_edge;
    logic               tick_a;
    logic               tick_s;
    logic               vote_bit;
    logic               bit_val;
    logic               step;
    logic               start_a;
    logic               start_s;
    logic [3:0]         nbits;
    logic [3:0]         pos;
    logic               frame_done;
    logic               fe_bit;
    logic               push_v;
    logic               drop;
    logic [ENTRY_W-1:0] entry;
    logic               fifo_in_ready;
    logic               fifo_out_valid;
    logic               fifo_pop;
    logic [ENTRY_W-1:0] head;
    logic               spi_sel;

    assign async_m = MODE == MODE_ASYNC;
    assign spi_m   = MODE == MODE_SPI;
    // rate and centre window follow double speed
    assign os_last = DOUBLE_SPEED ? OS_DOUBLE : OS_NORMAL;
    assign v_lo    = DOUBLE_SPEED ? VOTE_LO_D : VOTE_LO_N;
    assign v_hi    = DOUBLE_SPEED ? VOTE_HI_D : VOTE_HI_N;

    assign tick_a  = RX_ENABLE & async_m & BAUD_TICK;
    assign tick_s  = RX_ENABLE & ~async_m & samp_edge;
    // slave only listens while selected; master always
    assign spi_sel = MASTER | ~SS_IN_N;

    // two of three centre samples decide the bit
    assign vote_bit = (ones_q == 2'h2) | ((ones_q == 2'h1) & RXD);
    assign bit_val  = async_m ? vote_bit : RXD;
    assign step     = async_m ? (tick_a & cnt_q == v_hi & state_q != ST_IDLE)
                              : (tick_s & state_q != ST_IDLE);

    // falling edge re-arms every frame
    assign start_a = tick_a & state_q == ST_IDLE & prev_q & ~RXD;
    assign start_s = tick_s & state_q == ST_IDLE
                   & (spi_m ? spi_sel : ~RXD);

    always_comb begin
        if (spi_m)
            nbits = SPI_BITS;
        else if (CHAR_SIZE == CS_NINE)
            nbits = NINE_BITS;
        else
            nbits = DATA_BASE + {2'h0, CHAR_SIZE[1:0]};
    end

    // lsb arrives first; spi may reverse the order
    assign pos = (spi_m && !LSB_FIRST) ? 4'h7 - idx_q : idx_q;

    always_comb begin
        frame_done = 1'b0;
        fe_bit     = 1'b0;
        if (spi_m) begin
            frame_done = (state_q == ST_DATA && step && idx_q == 4'h7)
                       | (start_s && SPI_BITS == 4'h1);
        end else if (state_q == ST_STOP && step) begin
            frame_done = 1'b1;
            fe_bit     = ~bit_val;
        end
    end

    // entry keeps its own flags beside the data
    always_comb begin
        entry             = '0;
        entry[8:0]        = shift_q;
        if (spi_m) begin
            if (!LSB_FIRST)
                entry[pos] = bit_val;
            else
                entry[idx_q] = bit_val;
        end
        entry[E_NINTH]    = (nbits == NINE_BITS) & shift_q[8];
        entry[E_FE]       = fe_bit;
        entry[E_PE]       = perr_q & ~spi_m;
        entry[E_DOR]      = dor_mark_q;
    end

    // buffer full or already overrun: drop the frame
    assign drop     = frame_done & (overrun_q | ~fifo_in_ready);
    assign push_v   = frame_done & ~overrun_q;
    assign fifo_pop = RD_POP & fifo_out_valid & RX_ENABLE;

    usr_sck_edge u_edge (
        .clk   (CLK),
        .rst_n (RST_N),
        .en    (CE),
        .sck   (SCK_IN),
        .pol   (CLOCK_POL),
        .samp  (samp_edge)
    );

    usr_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk       (CLK),
        .rst_n     (RST_N),
        .en        (CE),
        .flush     (~RX_ENABLE),
        .in_valid  (push_v),
        .in_ready  (fifo_in_ready),
        .in_data   (entry),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (head)
    );

    // line history for edge search; moves on sample ticks, forced high while disabled
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N)
            prev_q <= 1'b1;
        else if (CE) begin
            if (!RX_ENABLE)
                prev_q <= 1'b1;
            else if (tick_a)
                prev_q <= RXD;
        end
    end

    // oversample position and centre vote count
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_q  <= OS_FIRST;
            ones_q <= 2'h0;
        end else if (CE) begin
            if (!RX_ENABLE || start_a) begin
                cnt_q  <= OS_FIRST;
                ones_q <= 2'h0;
            end else if (tick_a && state_q != ST_IDLE) begin
                cnt_q <= (cnt_q == os_last) ? OS_FIRST : cnt_q + 5'h01;
                if (cnt_q == v_hi)
                    ones_q <= 2'h0;
                else if (cnt_q >= v_lo && cnt_q < v_hi && RXD)
                    ones_q <= ones_q + 2'h1;
            end
        end
    end

    // frame sequencer
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N)
            state_q <= ST_IDLE;
        else if (CE) begin
            if (!RX_ENABLE || (spi_m && !spi_sel))
                state_q <= ST_IDLE;
            else begin
                unique case (state_q)
                    ST_IDLE: begin
                        if (start_a)
                            state_q <= ST_START;
                        else if (start_s)
                            state_q <= ST_DATA;
                    end
                    ST_START: begin
                        if (step)
                            // majority high means noise
                            state_q <= vote_bit ? ST_IDLE : ST_DATA;
                    end
                    ST_DATA: begin
                        if (step && idx_q == nbits - 4'h1)
                            state_q <= spi_m ? ST_IDLE
                                     : (PARITY_EN ? ST_PAR : ST_STOP);
                    end
                    ST_PAR: begin
                        if (step)
                            state_q <= ST_STOP;
                    end
                    ST_STOP: begin
                        // second stop bit never looked at
                        if (step)
                            state_q <= ST_IDLE;
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // shift register, bit index and parity accumulator
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            shift_q <= '0;
            idx_q   <= 4'h0;
            par_q   <= 1'b0;
            perr_q  <= 1'b0;
        end else if (CE) begin
            if (!RX_ENABLE) begin
                shift_q <= '0;
                idx_q   <= 4'h0;
                par_q   <= 1'b0;
                perr_q  <= 1'b0;
            end else if (start_a || (start_s && !spi_m)) begin
                shift_q <= '0;
                idx_q   <= 4'h0;
                par_q   <= 1'b0;
                perr_q  <= 1'b0;
            end else if (start_s && spi_m) begin
                shift_q <= '0;
                shift_q[LSB_FIRST ? 4'h0 : 4'h7] <= RXD;
                idx_q   <= 4'h1;
            end else if (step && state_q == ST_DATA) begin
                shift_q[pos] <= bit_val;
                par_q        <= par_q ^ bit_val;
                idx_q        <= idx_q + 4'h1;
            end else if (step && state_q == ST_PAR) begin
                perr_q <= bit_val != (par_q ^ PARITY_ODD);
            end
        end
    end

    // overrun: set wins over the clearing read
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            overrun_q  <= 1'b0;
            dor_mark_q <= 1'b0;
        end else if (CE) begin
            if (!RX_ENABLE) begin
                overrun_q  <= 1'b0;
                dor_mark_q <= 1'b0;
            end else begin
                if (drop)
                    overrun_q <= 1'b1;
                else if (fifo_pop)
                    overrun_q <= 1'b0;
                if (drop)
                    dor_mark_q <= 1'b1;
                else if (push_v && fifo_in_ready)
                    dor_mark_q <= 1'b0;
            end
        end
    end

    // registered status view of the buffer head
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RX_DATA     <= 8'h00;
            RX_NINTH    <= 1'b0;
            FRAME_ERR   <= 1'b0;
            PARITY_ERR  <= 1'b0;
            OVERRUN     <= 1'b0;
            RX_COMPLETE <= 1'b0;
            RX_IRQ      <= 1'b0;
        end else if (CE) begin
            RX_DATA     <= fifo_out_valid ? head[7:0] : 8'h00;
            RX_NINTH    <= fifo_out_valid & head[E_NINTH];
            FRAME_ERR   <= fifo_out_valid & head[E_FE];
            PARITY_ERR  <= fifo_out_valid & head[E_PE] & PARITY_EN;
            OVERRUN     <= overrun_q | (fifo_out_valid & head[E_DOR]);
            RX_COMPLETE <= fifo_out_valid;
            RX_IRQ      <= fifo_out_valid & RXC_IE & GLOBAL_IE;
        end
    end

    // pin ownership and slave select drive
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RX_BUSY       <= 1'b0;
            RXD_GPIO_FREE <= 1'b1;
            SS_OUT_N      <= 1'b1;
            SS_OE         <= 1'b0;
        end else if (CE) begin
            RX_BUSY       <= RX_ENABLE & state_q != ST_IDLE;
            RXD_GPIO_FREE <= ~RX_ENABLE;
            SS_OE         <= spi_m & MASTER & SS_OUT_EN;
            SS_OUT_N      <= ~(spi_m & MASTER & SS_OUT_EN & RX_ENABLE);
        end
    end

    a_disable_flush: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && !RX_ENABLE |=> state_q == ST_IDLE && !fifo_out_valid && !overrun_q)
        else $error("disable did not flush receiver");

    a_rxc_tracks: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && fifo_out_valid |=> RX_COMPLETE ##1 (RX_COMPLETE || !$past(fifo_out_valid)))
        else $error("complete flag does not follow buffer");

    a_irq_needs: assert property (@(posedge CLK) disable iff (!RST_N)
        RX_IRQ |-> RX_COMPLETE && $past(RXC_IE) && $past(GLOBAL_IE))
        else $error("interrupt without flag or enables");

    a_pe_zero: assert property (@(posedge CLK) disable iff (!RST_N)
        $past(CE) && !$past(PARITY_EN) |-> !PARITY_ERR)
        else $error("parity error shown while parity off");

    a_overrun_set: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && RX_ENABLE && frame_done && !fifo_in_ready |=> overrun_q ##1 OVERRUN || !CE)
        else $error("overrun not raised on full buffer");

    a_start_reject: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && RX_ENABLE && state_q == ST_START && step && vote_bit
        |=> state_q == ST_IDLE)
        else $error("rejected start bit not dropped");

    a_start_wait: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && RX_ENABLE && async_m && state_q == ST_START && tick_a && cnt_q < v_hi
        |=> state_q == ST_START)
        else $error("start decided before centre sample");

    a_stop_idle: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && RX_ENABLE && state_q == ST_STOP && step |=> state_q == ST_IDLE)
        else $error("receiver not idle after stop bit");

    a_fe_entry: assert property (@(posedge CLK) disable iff (!RST_N)
        async_m && state_q == ST_STOP && step && ones_q == 2'h0 |-> entry[E_FE])
        else $error("frame error does not match stop bit");
endmodule : usr_rx

// *** verilog/usr_pkg.sv ***
/*
 * constants for the serial receive path: modes, frame codes,
 * oversampling points and buffer entry layout.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package usr_pkg;
    // operating mode field codes
    localparam logic [1:0] MODE_ASYNC = 2'h0;
    localparam logic [1:0] MODE_SYNC  = 2'h1;
    localparam logic [1:0] MODE_SPI   = 2'h3;
    // char size field: 3'h7 is nine bits, else low two code bits + 5
    localparam logic [2:0] CS_NINE    = 3'h7;
    localparam logic [3:0] DATA_BASE  = 4'h5;
    localparam logic [3:0] NINE_BITS  = 4'h9;
    localparam logic [3:0] SPI_BITS   = 4'h8;
    // oversampling rates and centre sample windows
    localparam logic [4:0] OS_NORMAL  = 5'h10;
    localparam logic [4:0] OS_DOUBLE  = 5'h08;
    localparam logic [4:0] VOTE_LO_N  = 5'h08;
    localparam logic [4:0] VOTE_HI_N  = 5'h0a;
    localparam logic [4:0] VOTE_LO_D  = 5'h04;
    localparam logic [4:0] VOTE_HI_D  = 5'h06;
    localparam logic [4:0] OS_FIRST   = 5'h01;
    // buffer entry layout
    localparam int         ENTRY_W    = 12;
    localparam int         E_NINTH    = 8;
    localparam int         E_FE       = 9;
    localparam int         E_PE       = 10;
    localparam int         E_DOR      = 11;
    localparam int         RX_BUF_DEPTH = 2;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_START = 5'h02,
        ST_DATA  = 5'h04,
        ST_PAR   = 5'h08,
        ST_STOP  = 5'h10
    } usr_state_t;
endpackage : usr_pkg

// *** verilog/usr_sck_edge.sv ***
/*
 * serial clock sampling-edge detector for synchronous and spi modes.
 * assumes the clock pin is already synchronous to CLK.
 */
`timescale 1ns/1ps
module usr_sck_edge (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic en,
    // pin and polarity
    input  wire logic sck,
    input  wire logic pol,
    // one-cycle pulse on the sampling edge
    output logic      samp
);
    logic prev_q;
    logic armed_q;

    // first enabled cycle only loads history: reset value cannot fake an edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q  <= 1'b0;
            armed_q <= 1'b0;
            samp    <= 1'b0;
        end else if (en) begin
            prev_q  <= sck;
            armed_q <= 1'b1;
            // pol 0 samples on falling edge, pol 1 on rising
            samp    <= armed_q & (pol ? (sck & ~prev_q) : (~sck & prev_q));
        end
    end
endmodule : usr_sck_edge

// *** verilog/usr_fifo.sv ***
/*
 * small receive fifo with registered read data (show-ahead).
 * assumes the writer honours in_ready and the reader out_valid.
 */
`timescale 1ns/1ps
module usr_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             en,
    input  wire logic             flush,
    // write side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // read side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW-1:0]    rd_ptr_d;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = cnt_q != (AW+1)'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign push      = in_valid & in_ready;
    assign pop       = out_ready & out_valid;

    always_comb begin
        rd_ptr_d = rd_ptr_q;
        if (flush)
            rd_ptr_d = '0;
        else if (pop)
            rd_ptr_d = (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end else if (en) begin
            rd_ptr_q <= rd_ptr_d;
            if (flush) begin
                wr_ptr_q <= '0;
                cnt_q    <= '0;
            end else begin
                if (push)
                    wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
                cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (en && push && !flush)
            mem[wr_ptr_q] <= in_data;
    end

    // head word registered; bypass when the head is being written now
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            out_data <= '0;
        else if (en)
            out_data <= (push && !flush && wr_ptr_q == rd_ptr_d) ? in_data
                                                                 : mem[rd_ptr_d];
    end
endmodule : usr_fifo

// *** tb/usr_tx_model.sv ***
/*
 * remote uart transmitter: start bit, data lsb first, parity, stop.
 * assumes tick pulses once per oversample period of the receiver.
 */
`timescale 1ns/1ps
module usr_tx_model (
    // clock and oversample tick
    input  wire logic        clk,
    input  wire logic        tick,
    input  wire logic [4:0]  os,
    // frame request: line bits after the start bit
    input  wire logic        go,
    input  wire logic [11:0] bits,
    input  wire logic [3:0]  nbits,
    // serial line, idle high
    output logic             rxd,
    output logic             busy
);
    logic [13:0] sh_q  = 14'h3fff;
    logic [3:0]  nb_q  = 4'h0;
    logic [4:0]  cnt_q = 5'h00;

    assign rxd  = sh_q[0];
    assign busy = (nb_q != 4'h0);

    always_ff @(posedge clk) begin
        if (go && !busy) begin
            sh_q  <= {1'b1, bits, 1'b0};  // start low, data lsb first, parity, stop
            nb_q  <= nbits + 4'h1;
            cnt_q <= 5'h00;
        end else if (busy && tick) begin
            cnt_q <= (cnt_q == os - 5'h01) ? 5'h00 : cnt_q + 5'h01;
            if (cnt_q == os - 5'h01) begin
                // ones shift in, so the line idles high after the frame
                sh_q <= {1'b1, sh_q[13:1]};
                nb_q <= nb_q - 4'h1;
            end
        end
    end
endmodule : usr_tx_model

// *** tb/usr_rx_bench.sv ***
/*
 * bench for usr_rx: random async frames, error frames, overrun, disable.
 * assumes usr_tx_model drives the serial input line.
 */
`timescale 1ns/1ps
module usr_rx_bench;
    import usr_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, en = 1'b0, ds = 1'b0;
    logic        pe = 1'b0, odd = 1'b0, tick = 1'b0, ie = 1'b0, gie = 1'b0;
    logic        ss_n = 1'b1, pop = 1'b0, go = 1'b0, sck = 1'b0, sdat = 1'b1;
    logic [1:0]  mode = MODE_ASYNC;
    logic [2:0]  cs = 3'h3;
    logic [2:0]  cs_tab [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    logic [11:0] fr = 12'hfff;
    logic [3:0]  nb = 4'h0;
    logic [7:0]  rx_data;
    logic        ninth, fe, perr, dor, rxc, irq, busy_rx, gpio_free, rxd, busy;
    logic [31:0] seed = 32'h79f4c76b;
    int          failures = 0, num_checks = 0, cyc = 0;

    usr_rx #(.BUF_DEPTH(RX_BUF_DEPTH)) i_dut (
        .CLK(clk), .RST_N(rst_n), .CE(ce), .RX_ENABLE(en), .MODE(mode),
        .DOUBLE_SPEED(ds), .CHAR_SIZE(cs), .PARITY_EN(pe), .PARITY_ODD(odd),
        .CLOCK_POL(1'b0), .MASTER(1'b0), .SS_OUT_EN(1'b0), .LSB_FIRST(1'b1),
        .RXC_IE(ie), .GLOBAL_IE(gie), .BAUD_TICK(tick), .RXD(rxd & sdat), .SCK_IN(sck),
        .SS_IN_N(ss_n), .RD_POP(pop), .RX_DATA(rx_data), .RX_NINTH(ninth),
        .FRAME_ERR(fe), .PARITY_ERR(perr), .OVERRUN(dor), .RX_COMPLETE(rxc),
        .RX_IRQ(irq), .RX_BUSY(busy_rx), .RXD_GPIO_FREE(gpio_free),
        .SS_OUT_N(), .SS_OE());
    usr_tx_model i_tx (.clk(clk), .tick(tick), .os(ds ? OS_DOUBLE : OS_NORMAL),
        .go(go), .bits(fr), .nbits(nb), .rxd(rxd), .busy(busy));

    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(negedge clk) tick <= ~tick;
    // ceiling well above some 25 frames of at most 400 cycles each
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures++;
            tally_and_finish();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [3:0] dbits(input logic [2:0] c);
        return (c == CS_NINE) ? NINE_BITS : DATA_BASE + {1'b0, c};
    endfunction : dbits

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic send(input logic [8:0] d, input logic flip, input logic bad,
                        input logic full);
        logic [3:0] n;
        int i;
        n = dbits(cs);
        fr = 12'hfff;
        for (i = 0; i < 9; i++) begin
            if (i < n) fr[i] = d[i];
        end
        if (pe) fr[n] = ^(d & ((9'h001 << n) - 9'h001)) ^ odd ^ flip;
        fr[n + {3'h0, pe}] = ~bad;
        nb = n + {3'h0, pe} + 4'h1;
        @(negedge clk) go = 1'b1;
        @(negedge clk) go = 1'b0;
        for (i = 0; full && busy && i < 2000; i++) @(negedge clk);
        repeat (2) @(negedge clk);
    endtask : send
    task automatic pop_one();
        @(negedge clk) pop = 1'b1;
        @(negedge clk) pop = 1'b0;
        repeat (2) @(negedge clk);
    endtask : pop_one
    // synchronous frame, lsb first; data changes on rising sck, sampled on falling
    task automatic sync_frame(input logic [9:0] f);
        int i;
        for (i = 0; i < 10; i++) begin
            @(negedge clk) sdat = f[i];
            sck = 1'b1;
            repeat (4) @(negedge clk);
            sck = 1'b0;
            repeat (4) @(negedge clk);
        end
        sdat = 1'b1;
        repeat (4) @(negedge clk);
    endtask : sync_frame
    task automatic tally_and_finish();
        if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        logic [8:0] d;
        logic       flip;
        logic       bad;
        int         k;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        send(9'h0a5, 1'b0, 1'b0, 1'b1);
        chk({7'h0, rxc}, 8'h00);
        en = 1'b1;
        repeat (4) @(negedge clk);
        for (k = 0; k < 15; k++) begin
            seed = lfsr(seed);
            d = seed[8:0];
            cs = cs_tab[k % 5];
            {gie, ie, ds, odd, pe} = seed[13:9];
            flip = pe & (k % 3 == 2);
            bad = (k % 4 == 3);
            send(d, flip, bad, 1'b1);
            chk(rx_data, d[7:0] & ((8'h01 << dbits(cs)) - 8'h01));
            chk({3'h0, ninth, fe, perr, dor, irq},
                {3'h0, (cs == CS_NINE) & d[8], bad, flip, 1'b0, ie & gie});
            chk({7'h0, rxc}, 8'h01);
            pop_one();
            chk({7'h0, rxc}, 8'h00);
        end
        cs = 3'h3;
        pe = 1'b0;
        send(9'h0a5, 1'b0, 1'b0, 1'b1);
        send(9'h05a, 1'b0, 1'b0, 1'b1);
        send(9'h0ff, 1'b0, 1'b0, 1'b1);
        chk({dor, rxc, 6'h0}, 8'hc0);
        chk(rx_data, 8'ha5);
        pop_one();
        chk(rx_data, 8'h5a);
        chk({7'h0, dor}, 8'h00);
        pop_one();
        send(9'h03c, 1'b0, 1'b0, 1'b1);
        send(9'h0c3, 1'b0, 1'b0, 1'b0);
        repeat (60) @(negedge clk);
        en = 1'b0;
        repeat (2) @(negedge clk);
        chk({5'h0, busy_rx, rxc, gpio_free}, 8'h01);
        for (k = 0; busy && k < 2000; k++) @(negedge clk);
        en = 1'b1;
        repeat (4) @(negedge clk);
        send(9'h096, 1'b0, 1'b0, 1'b1);
        chk(rx_data, 8'h96);
        // short low glitch: start attempt must be taken, then rejected
        sdat = 1'b0;
        repeat (4) @(negedge clk);
        sdat = 1'b1;
        chk({7'h0, busy_rx}, 8'h01);
        repeat (40) @(negedge clk);
        chk({7'h0, busy_rx}, 8'h00);
        pop_one();
        mode = MODE_SYNC;
        sync_frame({1'b1, 8'h3c, 1'b0});
        chk(rx_data, 8'h3c);
        chk({6'h0, fe, rxc}, 8'h01);
        tally_and_finish();
    end
endmodule : usr_rx_bench
